/* core/line_driver_defines.vh */
// constants shared by the output-stage mode control design
// assumes a 25 MHz core clock; included by bare name
`ifndef LINE_DRIVER_DEFINES_VH
`define LINE_DRIVER_DEFINES_VH

// ***************************************************
// mode field encodings
// ***************************************************
`define MODE_OFF        3'h0
`define MODE_LOW_SIDE   3'h1
`define MODE_HIGH_SIDE  3'h2
`define MODE_PUSH_PULL  3'h3
`define MODE_TRI_STATE  3'h4
`define MODE_FORCE_LOW  3'h5
`define MODE_FORCE_HIGH 3'h6
`define MODE_PP_INDUCT  3'h7
`define MODE_RESET      3'h4

// ***************************************************
// register indices and field layout
// ***************************************************
`define IDX_CONFIG      3'h0
`define IDX_LED1_HI     3'h1
`define IDX_LED1_LO     3'h2
`define IDX_LED2_HI     3'h3
`define IDX_LED2_LO     3'h4
`define MODE_MSB        7
`define MODE_LSB        5
`define CFG_LOW_PAD     5'h00
`define LED_RESET       16'h0000
`define BYTE_ZERO       8'h00

// ***************************************************
// timing
// ***************************************************
`define CLK_PERIOD_NS   40
`define DEAD_TIME_NS    80
`define LED_STEP_MS     63
`define NS_PER_MS       1000000

`endif

/* core/dead_time_gate.v */
// break-before-make gate for the two output switches
// assumes requests come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module dead_time_gate #(
  parameter DT_CYCLES = 2,
  parameter CW        = 4
) (
  input  wire core_clk_i,
  input  wire nrst_i,
  input  wire want_hs_i,
  input  wire want_ls_i,
  output wire hs_on_o,
  output wire ls_on_o
);

  reg          hs_r;
  reg          ls_r;
  reg [CW-1:0] idle_cnt_r;
  wire         gap_done;

  // counter saturates, so a switch off for long turns on at once
  assign gap_done = (idle_cnt_r >= DT_CYCLES[CW-1:0]);
  assign hs_on_o  = hs_r;
  assign ls_on_o  = ls_r;

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hs_r       <= 1'b0;
      ls_r       <= 1'b0;
      idle_cnt_r <= DT_CYCLES[CW-1:0];
    end
    else
    begin
      hs_r <= want_hs_i && !ls_r && !want_ls_i && (hs_r || gap_done);
      ls_r <= want_ls_i && !hs_r && !want_hs_i && (ls_r || gap_done);
      if (hs_r || ls_r)
        idle_cnt_r <= {CW{1'b0}};
      else if (!gap_done)
        idle_cnt_r <= idle_cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* core/led_pattern_scan.v */
// steps through a 16-bit pattern, one bit per step period
// assumes the pattern is written by logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module led_pattern_scan #(
  parameter STEP_CYCLES = 1575000,
  parameter CW          = 21
) (
  input  wire        core_clk_i,
  input  wire        nrst_i,
  input  wire [15:0] pattern_i,
  output wire        led_on_o
);

  reg [CW-1:0] tick_r;
  reg [3:0]    bit_r;
  reg          led_r;

  assign led_on_o = led_r;

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tick_r <= {CW{1'b0}};
      bit_r  <= 4'h0;
      led_r  <= 1'b0;
    end
    else
    begin
      led_r <= pattern_i[bit_r];
      if (tick_r == STEP_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
      begin
        tick_r <= {CW{1'b0}};
        bit_r  <= bit_r + 4'h1;
      end
      else
        tick_r <= tick_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* core/line_driver_mode_control.v */
// output-stage mode control: switch gating, receiver, supply switch, leds
// assumes host pins are asynchronous and a 25 MHz core clock
`timescale 1ns/1ps
`default_nettype none
`include "line_driver_defines.vh"
module line_driver_mode_control #(
  parameter LED_STEP_CYCLES = 1575000,
  parameter LED_CW          = 21,
  parameter DT_CW           = 4
) (
  input  wire       core_clk_i,
  input  wire       nrst_i,
  input  wire       line_drive_enable_i,
  input  wire       tx_level_i,
  input  wire       line_sense_i,
  input  wire       supply_enable_i,
  input  wire       aux_sense_i,
  input  wire       wr_valid_i,
  input  wire [2:0] wr_idx_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_end_i,
  input  wire [2:0] rd_idx_i,
  input  wire       parity_err_clr_i,
  output wire       high_side_switch_o,
  output wire       low_side_switch_o,
  output wire       rx_out_o,
  output wire       rx_enabled_o,
  output wire       supply_switch_o,
  output wire       aux_rx_o,
  output wire       led1_on_o,
  output wire       led2_on_o,
  output wire [7:0] rd_data_o,
  output wire       parity_err_o
);

  // dead time rounded up to whole cycles, at least one
  localparam DT_RAW    = (`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam DT_CYCLES = (DT_RAW < 1) ? 1 : DT_RAW;

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  reg  [4:0] sync1_r;
  reg  [4:0] sync2_r;
  wire       en_s;
  wire       tx_s;
  wire       line_s;
  wire       sup_s;
  wire       aux_s;

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end
    else
    begin
      sync1_r <= {aux_sense_i, supply_enable_i, line_sense_i, tx_level_i,
                  line_drive_enable_i};
      sync2_r <= sync1_r;
    end
  end

  assign en_s   = sync2_r[0];
  assign tx_s   = sync2_r[1];
  assign line_s = sync2_r[2];
  assign sup_s  = sync2_r[3];
  assign aux_s  = sync2_r[4];

  // ***************************************************
  // registers and sequential write staging
  // ***************************************************
  function is_active;
    input [2:0] m;
    begin
      is_active = (m != `MODE_OFF) && (m != `MODE_TRI_STATE);
    end
  endfunction

  reg  [2:0]  mode_r;
  reg  [15:0] led1_r;
  reg  [15:0] led2_r;
  reg  [7:0]  stage_r [0:4];
  reg  [4:0]  staged_r;
  reg         perr_r;
  reg  [7:0]  rd_r;
  reg  [7:0]  stage_nxt [0:4];
  reg  [4:0]  staged_nxt;
  wire [2:0]  req_mode;
  wire        jump_bad;
  wire        commit;
  integer     k;
  integer     j;

  always @*
  begin
    staged_nxt = staged_r;
    for (k = 0; k < 5; k = k + 1)
      stage_nxt[k] = stage_r[k];
    if (wr_valid_i && (wr_idx_i <= `IDX_LED2_LO))
    begin
      stage_nxt[wr_idx_i]  = wr_data_i;
      staged_nxt[wr_idx_i] = 1'b1;
    end
  end

  assign req_mode = stage_nxt[`IDX_CONFIG][`MODE_MSB:`MODE_LSB];
  assign commit   = wr_valid_i && wr_end_i;
  assign jump_bad = staged_nxt[`IDX_CONFIG] && is_active(mode_r)
                    && is_active(req_mode) && (req_mode != mode_r);

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_r   <= `MODE_RESET;
      led1_r   <= `LED_RESET;
      led2_r   <= `LED_RESET;
      staged_r <= 5'h00;
      perr_r   <= 1'b0;
      for (j = 0; j < 5; j = j + 1)
        stage_r[j] <= `BYTE_ZERO;
    end
    else
    begin
      for (j = 0; j < 5; j = j + 1)
        stage_r[j] <= stage_nxt[j];
      staged_r <= commit ? 5'h00 : staged_nxt;
      if (commit && !jump_bad)
      begin
        if (staged_nxt[`IDX_CONFIG])
          mode_r <= req_mode;
        if (staged_nxt[`IDX_LED1_HI])
          led1_r[15:8] <= stage_nxt[`IDX_LED1_HI];
        if (staged_nxt[`IDX_LED1_LO])
          led1_r[7:0] <= stage_nxt[`IDX_LED1_LO];
        if (staged_nxt[`IDX_LED2_HI])
          led2_r[15:8] <= stage_nxt[`IDX_LED2_HI];
        if (staged_nxt[`IDX_LED2_LO])
          led2_r[7:0] <= stage_nxt[`IDX_LED2_LO];
      end
      // keep mode, flag error; set wins over clear
      if (commit && jump_bad)
        perr_r <= 1'b1;
      else if (parity_err_clr_i)
        perr_r <= 1'b0;
    end
  end

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_r <= `BYTE_ZERO;
    else
    begin
      case (rd_idx_i)
        `IDX_CONFIG  : rd_r <= {mode_r, `CFG_LOW_PAD};
        `IDX_LED1_HI : rd_r <= led1_r[15:8];
        `IDX_LED1_LO : rd_r <= led1_r[7:0];
        `IDX_LED2_HI : rd_r <= led2_r[15:8];
        `IDX_LED2_LO : rd_r <= led2_r[7:0];
        default      : rd_r <= `BYTE_ZERO;
      endcase
    end
  end

  assign rd_data_o    = rd_r;
  assign parity_err_o = perr_r;

  // ***************************************************
  // output stage decode
  // ***************************************************
  reg want_hs;
  reg want_ls;

  always @*
  begin
    want_hs = 1'b0;
    want_ls = 1'b0;
    case (mode_r)
      `MODE_OFF        : want_hs = 1'b0;
      `MODE_LOW_SIDE   : want_ls = tx_s && en_s;
      `MODE_HIGH_SIDE  : want_hs = !tx_s && en_s;
      `MODE_PUSH_PULL,
      `MODE_PP_INDUCT  :
      begin
        want_hs = en_s && !tx_s;
        want_ls = en_s && tx_s;
      end
      `MODE_TRI_STATE  : want_ls = 1'b0;
      `MODE_FORCE_LOW  : want_ls = 1'b1;
      `MODE_FORCE_HIGH : want_hs = 1'b1;
      default          : want_hs = 1'b0;
    endcase
  end

  dead_time_gate #(
    .DT_CYCLES (DT_CYCLES),
    .CW        (DT_CW)
  ) u_gate (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .want_hs_i  (want_hs),
    .want_ls_i  (want_ls),
    .hs_on_o    (high_side_switch_o),
    .ls_on_o    (low_side_switch_o)
  );

  // ***************************************************
  // receivers and supply switch
  // ***************************************************
  reg rx_en_r;
  reg rx_out_r;
  reg sup_r;
  reg aux_r;

  always @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_en_r  <= 1'b0;
      rx_out_r <= 1'b1;
      sup_r    <= 1'b0;
      aux_r    <= 1'b0;
    end
    else
    begin
      rx_en_r  <= (mode_r != `MODE_OFF) && !en_s;
      rx_out_r <= ((mode_r != `MODE_OFF) && !en_s) ? !line_s : 1'b1;
      sup_r    <= sup_s;
      aux_r    <= aux_s;
    end
  end

  assign rx_enabled_o    = rx_en_r;
  assign rx_out_o        = rx_out_r;
  assign supply_switch_o = sup_r;
  assign aux_rx_o        = aux_r;

  // ***************************************************
  // led pattern scanners
  // ***************************************************
  wire [31:0] led_pat;
  wire [1:0]  led_on;

  assign led_pat   = {led2_r, led1_r};
  assign led1_on_o = led_on[0];
  assign led2_on_o = led_on[1];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_led
      led_pattern_scan #(
        .STEP_CYCLES (LED_STEP_CYCLES),
        .CW          (LED_CW)
      ) u_scan (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .pattern_i  (led_pat[16*g+15:16*g]),
        .led_on_o   (led_on[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

/* tb/drv_monitor.sv */
// checker on the mode control ports
// assumes it is bound into line_driver_mode_control
`timescale 1ns/1ps
`default_nettype none
module drv_monitor (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic line_sense_i,
  input wire logic supply_enable_i,
  input wire logic aux_sense_i,
  input wire logic wr_end_i,
  input wire logic parity_err_clr_i,
  input wire logic high_side_switch_o,
  input wire logic low_side_switch_o,
  input wire logic rx_out_o,
  input wire logic rx_enabled_o,
  input wire logic supply_switch_o,
  input wire logic aux_rx_o,
  input wire logic parity_err_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  // ****************************************
  // assertions
  // ****************************************
  no_overlap_a: assert property (!(high_side_switch_o && low_side_switch_o))
    else $error("both switches on");
  dead_hs_ls_a: assert property ($fell(high_side_switch_o) |-> !low_side_switch_o [*2])
    else $error("low side on too soon");
  dead_ls_hs_a: assert property ($fell(low_side_switch_o) |-> !high_side_switch_o [*2])
    else $error("high side on too soon");
  rx_off_high_a: assert property (!rx_enabled_o |-> rx_out_o)
    else $error("receive output low while receiver off");
  rx_inverts_a: assert property (line_sense_i [*4] ##0 rx_enabled_o |-> !rx_out_o)
    else $error("receive output not inverted");
  supply_on_a: assert property (supply_enable_i [*4] |-> supply_switch_o)
    else $error("supply switch not on");
  supply_off_a: assert property (!supply_enable_i [*4] |-> !supply_switch_o)
    else $error("supply switch not off");
  aux_follow_a: assert property (aux_sense_i [*4] |-> aux_rx_o)
    else $error("aux receiver not following");
  parity_hold_a: assert property (parity_err_o && !parity_err_clr_i |=> parity_err_o)
    else $error("parity error dropped");
  parity_cause_a: assert property ($rose(parity_err_o) |-> $past(wr_end_i) || $past(wr_end_i, 2))
    else $error("parity error without a commit");
  hs_seen_c: cover property ($rose(high_side_switch_o));
  ls_seen_c: cover property ($rose(low_side_switch_o));
  perr_seen_c: cover property ($rose(parity_err_o));
  ls_to_hs_c: cover property ($fell(low_side_switch_o) ##[1:4] $rose(high_side_switch_o));
endmodule
`default_nettype wire

/* tb/line_load.sv */
// far-end line model seen by the output switches
// assumes the switch controls are active high
`timescale 1ns/1ps
`default_nettype none
module line_load (
  input  wire logic hs_i,
  input  wire logic ls_i,
  input  wire logic float_i,
  output wire logic sense_o
);
  // an undriven line shows the sensor level, never a stale drive
  assign sense_o = hs_i ? 1'b1 : (ls_i ? 1'b0 : float_i);
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for line_driver_mode_control
// assumes pin latency below 8 cycles, led step shortened to 4
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, nrst = 0, en = 0, tx = 0, sup = 0, aux = 0, flt = 0;
  logic        wv = 0, we = 0, clr = 0, smp = 0, pexp = 0, l1x = 0, l2x = 0;
  logic [2:0]  wi = 0, ri = 0, md = 0;
  logic [7:0]  wd = 0;
  wire         hs, ls, rxo, rxe, sw, axo, l1, l2, pe, sense;
  wire  [7:0]  rd;
  logic [16:0] q[$];
  int          n_fail = 0, comparisons = 0, cyc = 0, seed = 32'h7074;
  always #20 clk = ~clk;
  line_driver_mode_control #(.LED_STEP_CYCLES(4)) DUT (.core_clk_i(clk), .nrst_i(nrst),
    .line_drive_enable_i(en), .tx_level_i(tx), .line_sense_i(sense), .supply_enable_i(sup),
    .aux_sense_i(aux), .wr_valid_i(wv), .wr_idx_i(wi), .wr_data_i(wd), .wr_end_i(we),
    .rd_idx_i(ri), .parity_err_clr_i(clr), .high_side_switch_o(hs), .low_side_switch_o(ls),
    .rx_out_o(rxo), .rx_enabled_o(rxe), .supply_switch_o(sw), .aux_rx_o(axo),
    .led1_on_o(l1), .led2_on_o(l2), .rd_data_o(rd), .parity_err_o(pe));
  line_load LINE (.hs_i(hs), .ls_i(ls), .float_i(flt), .sense_o(sense));
  // ****************************************
  // expectations and comparison
  // ****************************************
  function automatic [16:0] exv();
    logic h, l, s;
    h = (md == 3'h2 || md == 3'h3 || md == 3'h7) && en && !tx || md == 3'h6;
    l = (md == 3'h1 || md == 3'h3 || md == 3'h7) && en && tx || md == 3'h5;
    s = h ? 1'b1 : (l ? 1'b0 : flt);
    return {h, l, md == 3'h0 || en || !s, md != 3'h0 && !en, sup, aux, l1x, l2x, pexp,
            ri == 3'h0 ? {md, 5'h00} :
            (ri == 3'h1 || ri == 3'h2) ? {8{l1x}} :
            (ri == 3'h3 || ri == 3'h4) ? {8{l2x}} : 8'h00};
  endfunction
  task automatic cmp(input logic [16:0] e);
    logic [16:0] g;
    g = {hs, ls, rxo, rxe, sw, axo, l1, l2, pe, rd};
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  always @(negedge clk) if (smp) cmp(q.pop_front());
  task automatic wr(input logic [2:0] i, input logic [7:0] d, input logic e);
    @(posedge clk);
    #1 {wv, wi, wd, we} = {1'b1, i, d, e};
    @(posedge clk);
    #1 {wv, we} = 2'b00;
  endtask
  // wait out sync, gate and dead time, then note the expectation
  task automatic look();
    repeat (8) @(posedge clk);
    #1 q.push_back(exv());
    smp = 1;
    @(posedge clk);
    #1 smp = 0;
  endtask
  task close_out;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      close_out;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clk);
    #1 nrst = 1;
    md = 3'h4;
    look();
    wr(3'h1, 8'hFF, 1'b0);
    wr(3'h2, 8'hFF, 1'b1);
    l1x = 1;
    for (int k = 0; k < 8; k++)
    begin
      wr(3'h0, 8'h00, 1'b1);
      wr(3'h0, {k[2:0], 5'h00}, 1'b1);
      md = k[2:0];
      for (int j = 0; j < 4; j++)
      begin
        {en, tx} = j[1:0];
        {sup, aux, flt} = 3'($random(seed));
        look();
      end
    end
    wr(3'h3, 8'hFF, 1'b0);
    wr(3'h4, 8'hFF, 1'b0);
    wr(3'h0, 8'h20, 1'b1);
    pexp = 1;
    ri = 3'h3;
    look();
    clr = 1;
    repeat (2) @(posedge clk);
    #1 clr = 0;
    pexp = 0;
    // same mode rewritten: the led2 bytes of this sequence must land
    wr(3'h3, 8'hFF, 1'b0);
    wr(3'h4, 8'hFF, 1'b0);
    wr(3'h0, 8'hE0, 1'b1);
    l2x = 1;
    ri = 3'h4;
    look();
    ri = 3'h5;
    look();
    close_out;
  end
endmodule
bind line_driver_mode_control drv_monitor MON (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .line_sense_i(line_sense_i), .supply_enable_i(supply_enable_i), .aux_sense_i(aux_sense_i),
  .wr_end_i(wr_end_i), .parity_err_clr_i(parity_err_clr_i),
  .high_side_switch_o(high_side_switch_o), .low_side_switch_o(low_side_switch_o),
  .rx_out_o(rx_out_o), .rx_enabled_o(rx_enabled_o), .supply_switch_o(supply_switch_o),
  .aux_rx_o(aux_rx_o), .parity_err_o(parity_err_o));
`default_nettype wire
